// >>> design/mean_divider.sv
`timescale 1ns/1ns
module mean_divider #(
  parameter int SUM_W = 40,
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    sys_rst_in,
  // Control
  input  wire logic                    start_in,
  input  wire logic                    abort_in,
  input  wire logic signed [SUM_W-1:0] sum_in,
  input  wire logic [CNT_W-1:0]        count_in,
  // Result
  output logic                         done_out,
  output logic signed [15:0]           mean_out
);
  localparam int IW = $clog2(SUM_W + 1);

  logic [SUM_W-1:0] quo_reg;
  logic [CNT_W:0]   rem_reg;
  logic [CNT_W:0]   rem_sh;
  logic [CNT_W-1:0] div_reg;
  logic [IW-1:0]    iter_reg;
  logic             neg_reg;
  logic             busy_reg;

  assign rem_sh   = {rem_reg[CNT_W-1:0], quo_reg[SUM_W-1]};
  assign mean_out = neg_reg ? -quo_reg[15:0] : quo_reg[15:0];

  // Restoring division of the sum magnitude
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      quo_reg  <= '0;
      rem_reg  <= '0;
      div_reg  <= '0;
      iter_reg <= '0;
      neg_reg  <= 1'b0;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_reg <= 1'b0;
      end else if (start_in) begin
        busy_reg <= 1'b1;
        neg_reg  <= sum_in[SUM_W-1];
        quo_reg  <= sum_in[SUM_W-1] ? -sum_in : sum_in;
        rem_reg  <= '0;
        div_reg  <= count_in;
        iter_reg <= IW'(SUM_W);
      end else if (busy_reg) begin
        if (rem_sh >= {1'b0, div_reg}) begin
          rem_reg <= rem_sh - {1'b0, div_reg};
          quo_reg <= {quo_reg[SUM_W-2:0], 1'b1};
        end else begin
          rem_reg <= rem_sh;
          quo_reg <= {quo_reg[SUM_W-2:0], 1'b0};
        end
        iter_reg <= iter_reg - 1'b1;
        if (iter_reg == IW'(1)) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> design/ssp_params.svh
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_OFFSET    8'h04
`define ADDR_GAIN      8'h08
`define ADDR_RANGE     8'h0C
`define ADDR_CFG0      8'h10
`define ADDR_SP0       8'h14
`define ADDR_CFG1      8'h18
`define ADDR_SP1       8'h1C
`define ADDR_TEACH     8'h20
`define ADDR_PD        8'h24
`define ADDR_STATUS    8'h28

// Field positions
`define CTRL_ALT_BIT   0
`define CTRL_SCALE_LSB 8
`define CFG_TEACH_BIT  2
`define CFG_DYN_BIT    3
`define CFG_POL_BIT    4
`define CFG_HYST_LSB   16
`define CMD_CH_BIT     3
`define CMD_SP_BIT     4

// Reset values and masks
`define RST_CTRL       32'h0000_0000
`define RST_OFFSET     32'h0000_0000
`define RST_GAIN       16'h0001
`define RST_RANGE_LO   16'h8300
`define RST_RANGE_HI   16'h7D00
`define CTRL_MASK      32'h0000_FF01
`define CFG_MASK       32'hFFFF_001F

// Process data values
`define PD_MIN         16'sh8300
`define PD_MAX         16'sh7D00
`define SUBST_HI       16'h7FF8
`define SUBST_LO       16'h8008
`define PD_VENDOR      6'h00
`define OFFSET_SCALER  32'sh0000_0001

// Bus answers
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// >>> design/ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [1:0] {
    SW_OFF    = 2'h0,
    SW_SINGLE = 2'h1,
    SW_TWO    = 2'h2,
    SW_WINDOW = 2'h3
  } sw_mode_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_ACQ  = 3'b010,
    T_DIV  = 3'b100
  } teach_state_t;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_STATIC = 3'h1,
    CMD_START  = 3'h2,
    CMD_STOP   = 3'h3,
    CMD_CANCEL = 3'h4
  } teach_cmd_t;

endpackage

// >>> design/ssp_scaling_and_switching.sv
`timescale 1ns/1ns
`include "ssp_params.svh"
// Function
// - Rescale 24-bit counts or 32-bit alternate counts
// - Output signed 16-bit value within +-32000
// - Linear map via programmable offset and gain
// - Offset multiplier fixed at one
// - No clamping at the two scaling points
// - Programmable lower and upper measurement limits
// - Out of range flags and sends substitute
// - Two independent switching channels
// - Switching configuration takes effect at the next sample; deactivation and polarity at once
// - Deactivated channel holds output low
// - Single point uses SP1 with hysteresis
// - Two point switches between both setpoints
// - Window mode with hysteresis at edges
// - Manual mode stores written setpoints
// - Teach mode derives setpoints, blocks writes
// - Static teach captures current process value
// - Dynamic teach stores mean of samples
// - Cancel aborts teach, keeps setpoint
// - Per channel polarity inverts output
// - Process data word field layout
module ssp_scaling_and_switching #(
  parameter int GAIN_FRAC = 20,
  parameter int SUM_W     = 40,
  parameter int CNT_W     = 24
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Conditioned data
  input  wire logic [23:0] cond_data_in,
  input  wire logic [31:0] alt_data_in,
  input  wire logic        data_valid_in,
  // AXI4-Lite write
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic [2:0]  awprot_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  output logic [1:0]       bresp_out,
  // AXI4-Lite read
  input  wire logic        arvalid_in,
  output logic             arready_out,
  input  wire logic [7:0]  araddr_in,
  input  wire logic [2:0]  arprot_in,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  // Process data
  output logic [31:0]      process_data_out,
  output logic             pd_valid_out,
  output logic             out_of_range_out,
  output logic [1:0]       switch_out
);
  import ssp_pkg::*;

  logic [31:0]             ctrl_reg;
  logic signed [31:0]      offset_reg;
  logic signed [15:0]      gain_reg;
  logic signed [15:0]      range_lo_reg;
  logic signed [15:0]      range_hi_reg;
  logic [31:0]             cfg_reg [2];
  logic signed [15:0]      sp1_reg [2];
  logic signed [15:0]      sp2_reg [2];
  logic [1:0]              level;
  logic [1:0]              sp_wr;
  logic [1:0]              cfg_wr;
  logic                    wr_go;
  logic                    wr_fire;
  logic                    wr_hit;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  logic signed [31:0]      src;
  logic signed [47:0]      prod_reg;
  logic                    s1_vld_reg;
  logic signed [47:0]      scaled;
  logic signed [15:0]      scaled_lo;
  logic                    in_range;
  logic                    below;
  logic signed [15:0]      meas_next;
  logic signed [15:0]      meas_reg;
  logic [31:0]             pd_reg;
  teach_state_t            t_state;
  teach_cmd_t              cmd;
  logic                    cmd_wr;
  logic                    cmd_ch;
  logic                    cmd_ok;
  logic                    cmd_dyn;
  logic                    t_ch_reg;
  logic                    t_sp_reg;
  logic signed [SUM_W-1:0] sum_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    static_ld;
  logic                    div_start;
  logic                    div_abort;
  logic                    div_done;
  logic signed [15:0]      div_mean;
  logic                    teach_ld;
  logic                    teach_ch;
  logic                    teach_sp;
  logic signed [15:0]      teach_val;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // Write channel: both address and data taken together
  assign wr_go   = awvalid_in & wvalid_in & ~awready_out & ~bvalid_out;
  assign wr_fire = awready_out;

  always_comb begin
    case (awaddr_in)
      `ADDR_CTRL, `ADDR_OFFSET, `ADDR_GAIN, `ADDR_RANGE, `ADDR_CFG0, `ADDR_SP0,
      `ADDR_CFG1, `ADDR_SP1, `ADDR_TEACH, `ADDR_PD, `ADDR_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      awready_out <= 1'b0;
      wready_out  <= 1'b0;
    end else begin
      awready_out <= wr_go;
      wready_out  <= wr_go;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_out <= 1'b1;
      bresp_out  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  // Read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (araddr_in)
      `ADDR_CTRL:   rd_data = ctrl_reg;
      `ADDR_OFFSET: rd_data = offset_reg;
      `ADDR_GAIN:   rd_data = {16'h0000, gain_reg};
      `ADDR_RANGE:  rd_data = {range_hi_reg, range_lo_reg};
      `ADDR_CFG0:   rd_data = cfg_reg[0];
      `ADDR_SP0:    rd_data = {sp2_reg[0], sp1_reg[0]};
      `ADDR_CFG1:   rd_data = cfg_reg[1];
      `ADDR_SP1:    rd_data = {sp2_reg[1], sp1_reg[1]};
      `ADDR_TEACH:  rd_data = {29'h0000_0000, t_state};
      `ADDR_PD:     rd_data = pd_reg;
      `ADDR_STATUS: rd_data = {30'h0000_0000, t_state != T_IDLE, out_of_range_out};
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0000_0000;
      rresp_out   <= `RESP_OKAY;
    end else begin
      arready_out <= arvalid_in & ~arready_out & ~rvalid_out;
      if (arready_out) begin
        rvalid_out <= 1'b1;
        rdata_out  <= rd_data;
        rresp_out  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end

  // Scaling and range registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_reg     <= `RST_CTRL;
      offset_reg   <= `RST_OFFSET;
      gain_reg     <= `RST_GAIN;
      range_lo_reg <= `RST_RANGE_LO;
      range_hi_reg <= `RST_RANGE_HI;
    end else if (wr_fire) begin
      case (awaddr_in)
        `ADDR_CTRL:   ctrl_reg <= merge(ctrl_reg, wdata_in, wstrb_in) & `CTRL_MASK;
        `ADDR_OFFSET: offset_reg <= merge(offset_reg, wdata_in, wstrb_in);
        `ADDR_GAIN:   gain_reg <= 16'(merge({16'h0000, gain_reg}, wdata_in, wstrb_in));
        `ADDR_RANGE:  {range_hi_reg, range_lo_reg} <= merge({range_hi_reg, range_lo_reg}, wdata_in, wstrb_in);
        default: ;
      endcase
    end
  end

  // Teach command decode
  assign cmd_wr    = wr_fire & (awaddr_in == `ADDR_TEACH) & wstrb_in[0];
  assign cmd       = teach_cmd_t'(wdata_in[2:0]);
  assign cmd_ch    = wdata_in[`CMD_CH_BIT];
  assign cmd_ok    = cfg_reg[cmd_ch][`CFG_TEACH_BIT] & (cfg_reg[cmd_ch][1:0] != SW_OFF);
  assign cmd_dyn   = cfg_reg[cmd_ch][`CFG_DYN_BIT];
  assign static_ld = cmd_wr & (cmd == CMD_STATIC) & cmd_ok & ~cmd_dyn & (t_state == T_IDLE);
  assign div_start = cmd_wr & (cmd == CMD_STOP) & (t_state == T_ACQ) & (cnt_reg != '0);
  assign div_abort = cmd_wr & (cmd == CMD_CANCEL) & (t_state == T_DIV);
  assign teach_ld  = static_ld | (div_done & (t_state == T_DIV) & ~div_abort);
  assign teach_ch  = static_ld ? cmd_ch : t_ch_reg;
  assign teach_sp  = static_ld ? wdata_in[`CMD_SP_BIT] : t_sp_reg;
  assign teach_val = static_ld ? meas_reg : div_mean;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      t_state  <= T_IDLE;
      t_ch_reg <= 1'b0;
      t_sp_reg <= 1'b0;
      sum_reg  <= '0;
      cnt_reg  <= '0;
    end else begin
      case (t_state)
        T_IDLE: begin
          if (cmd_wr & (cmd == CMD_START) & cmd_ok & cmd_dyn) begin
            t_state  <= T_ACQ;
            t_ch_reg <= cmd_ch;
            t_sp_reg <= wdata_in[`CMD_SP_BIT];
            sum_reg  <= '0;
            cnt_reg  <= '0;
          end
        end
        T_ACQ: begin
          if (cmd_wr & (cmd == CMD_CANCEL)) begin
            t_state <= T_IDLE;
          end else if (cmd_wr & (cmd == CMD_STOP)) begin
            t_state <= div_start ? T_DIV : T_IDLE;
          end else if (pd_valid_out & ~&cnt_reg) begin
            sum_reg <= sum_reg + SUM_W'(meas_reg);
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        T_DIV: begin
          if (div_abort | div_done) t_state <= T_IDLE;
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  mean_divider #(
    .SUM_W (SUM_W),
    .CNT_W (CNT_W)
  ) u_mean (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (div_start),
    .abort_in   (div_abort),
    .sum_in     (sum_reg),
    .count_in   (cnt_reg),
    .done_out   (div_done),
    .mean_out   (div_mean)
  );

  // Per channel configuration, setpoints and switching
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign cfg_wr[c] = wr_fire & (awaddr_in == (c == 0 ? `ADDR_CFG0 : `ADDR_CFG1));
    assign sp_wr[c]  = wr_fire & (awaddr_in == (c == 0 ? `ADDR_SP0 : `ADDR_SP1));

    always_ff @(posedge clock_in) begin
      if (sys_rst_in) cfg_reg[c] <= 32'h0000_0000;
      else if (cfg_wr[c]) cfg_reg[c] <= merge(cfg_reg[c], wdata_in, wstrb_in) & `CFG_MASK;
    end

    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        sp1_reg[c] <= 16'h0000;
        sp2_reg[c] <= 16'h0000;
      end else if (teach_ld & (teach_ch == 1'(c))) begin
        if (teach_sp) sp2_reg[c] <= teach_val;
        else sp1_reg[c] <= teach_val;
      end else if (sp_wr[c] & ~cfg_reg[c][`CFG_TEACH_BIT]) begin
        {sp2_reg[c], sp1_reg[c]} <= merge({sp2_reg[c], sp1_reg[c]}, wdata_in, wstrb_in);
      end
    end

    switch_channel u_sw (
      .clock_in      (clock_in),
      .sys_rst_in    (sys_rst_in),
      .eval_in       (s1_vld_reg),
      .value_in      (meas_next),
      .mode_in       (sw_mode_t'(cfg_reg[c][1:0])),
      .sp1_in        (sp1_reg[c]),
      .sp2_in        (sp2_reg[c]),
      .hyst_in       (cfg_reg[c][`CFG_HYST_LSB +: 16]),
      .low_active_in (cfg_reg[c][`CFG_POL_BIT]),
      .level_out     (level[c])
    );
  end

  // Scaling pipeline
  assign src = ctrl_reg[`CTRL_ALT_BIT] ? $signed(alt_data_in) : 32'(signed'(cond_data_in));

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prod_reg   <= '0;
      s1_vld_reg <= 1'b0;
    end else begin
      s1_vld_reg <= data_valid_in;
      if (data_valid_in) prod_reg <= src * gain_reg;
    end
  end

  assign scaled    = (prod_reg >>> GAIN_FRAC) + 48'(offset_reg * `OFFSET_SCALER);
  assign scaled_lo = scaled[15:0];
  assign in_range  = (scaled >= range_lo_reg) & (scaled <= range_hi_reg)
                   & (scaled >= `PD_MIN) & (scaled <= `PD_MAX);
  assign below     = (scaled < range_lo_reg) | (scaled < `PD_MIN);
  assign meas_next = in_range ? scaled_lo : (below ? `SUBST_LO : `SUBST_HI);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      meas_reg         <= 16'h0000;
      out_of_range_out <= 1'b0;
      pd_valid_out     <= 1'b0;
      pd_reg           <= 32'h0000_0000;
    end else begin
      pd_valid_out <= s1_vld_reg;
      pd_reg[15:0] <= {ctrl_reg[`CTRL_SCALE_LSB +: 8], `PD_VENDOR, level};
      if (s1_vld_reg) begin
        meas_reg         <= meas_next;
        out_of_range_out <= ~in_range;
        pd_reg[31:16]    <= meas_next;
      end
    end
  end

  assign process_data_out = pd_reg;
  assign switch_out       = pd_reg[1:0];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  alt_source_a: assert property (data_valid_in && ctrl_reg[`CTRL_ALT_BIT] |=>
    prod_reg == $signed($past(alt_data_in)) * $past(gain_reg))
    else $error("alternate source not scaled");
  pd_span_a: assert property (pd_valid_out |->
    ($signed(pd_reg[31:16]) >= `PD_MIN && $signed(pd_reg[31:16]) <= `PD_MAX)
    || pd_reg[31:16] == `SUBST_HI || pd_reg[31:16] == `SUBST_LO)
    else $error("measurement outside process range");
  pass_through_a: assert property (s1_vld_reg && in_range |=>
    meas_reg == $past(scaled_lo) && !out_of_range_out)
    else $error("in range value altered");
  oor_subst_a: assert property (s1_vld_reg && !in_range |=>
    out_of_range_out && (meas_reg == `SUBST_LO || meas_reg == `SUBST_HI))
    else $error("substitute missing");
  off_low_a: assert property (cfg_reg[0][1:0] == SW_OFF |=> !pd_reg[0])
    else $error("deactivated channel not low");
  teach_lock_a: assert property (sp_wr[1] && cfg_reg[1][`CFG_TEACH_BIT] && !teach_ld |=>
    $stable(sp1_reg[1]) && $stable(sp2_reg[1]))
    else $error("setpoint written in teach mode");
  static_teach_a: assert property (static_ld && cmd_ch && !wdata_in[`CMD_SP_BIT] |=>
    sp1_reg[1] == $past(meas_reg))
    else $error("static teach missed");
  cancel_keep_a: assert property (cmd_wr && cmd == CMD_CANCEL && t_state != T_IDLE |->
    !teach_ld ##1 t_state == T_IDLE ##1 !div_done)
    else $error("cancel did not abort");
  together_a: assert property (!s1_vld_reg |=>
    !pd_valid_out && $stable(meas_reg) && $stable(out_of_range_out))
    else $error("update without new sample");
endmodule

// >>> design/switch_channel.sv
`timescale 1ns/1ns
module switch_channel (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  // Measurement
  input  wire logic               eval_in,
  input  wire logic signed [15:0] value_in,
  // Configuration
  input  wire ssp_pkg::sw_mode_t  mode_in,
  input  wire logic signed [15:0] sp1_in,
  input  wire logic signed [15:0] sp2_in,
  input  wire logic [15:0]        hyst_in,
  input  wire logic               low_active_in,
  // Switching level
  output logic                    level_out
);
  import ssp_pkg::*;

  logic signed [17:0] v;
  logic signed [17:0] a;
  logic signed [17:0] b;
  logic signed [17:0] lo;
  logic signed [17:0] hi;
  logic signed [17:0] h;
  logic               state_reg;
  logic               state_next;
  logic               eval_state;

  assign v  = 18'(value_in);
  assign a  = 18'(sp1_in);
  assign b  = 18'(sp2_in);
  assign h  = $signed({2'b00, hyst_in});
  assign lo = (a < b) ? a : b;
  assign hi = (a < b) ? b : a;

  always_comb begin
    state_next = state_reg;
    case (mode_in)
      SW_SINGLE: begin
        if (v >= a) state_next = 1'b1;
        else if (v < a - h) state_next = 1'b0;
      end
      SW_TWO: begin
        if (v >= hi) state_next = 1'b1;
        else if (v < lo) state_next = 1'b0;
      end
      SW_WINDOW: begin
        if (v >= lo && v <= hi) state_next = 1'b1;
        else if (v < lo - h || v > hi + h) state_next = 1'b0;
      end
      default: state_next = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) state_reg <= 1'b0;
    else if (mode_in == SW_OFF) state_reg <= 1'b0;
    else if (eval_in) state_reg <= state_next;
  end

  assign eval_state = eval_in ? state_next : state_reg;
  assign level_out  = (mode_in != SW_OFF) & (eval_state ^ low_active_in);
endmodule

// >>> tb/pd_reader.sv
`timescale 1ns/1ns
module pd_reader (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Process data
  input  wire logic        pd_valid_in,
  input  wire logic [31:0] pd_in,
  // Captured word
  output logic [31:0]      last_pd_out
);
  // Takes each word on its valid pulse
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      last_pd_out <= 32'h0000_0000;
    end else if (pd_valid_in) begin
      last_pd_out <= pd_in;
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ssp_pkg::*;
  typedef struct packed {logic [23:0] src; logic [15:0] meas; logic oor; logic sw;} row_t;
  logic clock_in, sys_rst_in, data_valid_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic [23:0] cond_data_in;
  logic [31:0] alt_data_in, wdata_in, rdata_out, process_data_out, last_pd, d;
  logic [7:0]  awaddr_in, araddr_in;
  logic [2:0]  awprot_in, arprot_in;
  logic [3:0]  wstrb_in;
  logic [1:0]  bresp_out, rresp_out, switch_out, r;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, pd_valid_out, out_of_range_out;
  int          n_errors, num_checks;
  row_t rows [7] = '{
    '{24'h00FA00, 16'h03E8, 1'b0, 1'b1}, '{24'h00ED80, 16'h03B6, 1'b0, 1'b1},
    '{24'h00E0C0, 16'h0383, 1'b0, 1'b0}, '{24'h1F4000, 16'h7D00, 1'b0, 1'b1},
    '{24'h1F4040, 16'h7FF8, 1'b1, 1'b1}, '{24'hE0BFC0, 16'h8008, 1'b1, 1'b0},
    '{24'hE0C000, 16'h8300, 1'b0, 1'b0}};
  ssp_scaling_and_switching u_dut (.*);
  pd_reader u_pd (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .pd_valid_in(pd_valid_out),
                  .pd_in(process_data_out), .last_pd_out(last_pd));
  initial begin
    clock_in = 0;
    forever #5 clock_in = ~clock_in;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    awaddr_in <= a; wdata_in <= v; awvalid_in <= 1; wvalid_in <= 1; bready_in <= 1;
    do @(posedge clock_in); while (!(awready_out && wready_out));
    awvalid_in <= 0; wvalid_in <= 0;
    do @(posedge clock_in); while (!bvalid_out);
    r = bresp_out; bready_in <= 0;
    @(posedge clock_in);
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_in);
    araddr_in <= a; arvalid_in <= 1; rready_in <= 1;
    do @(posedge clock_in); while (!arready_out);
    arvalid_in <= 0;
    do @(posedge clock_in); while (!rvalid_out);
    d = rdata_out; r = rresp_out; rready_in <= 0;
    @(posedge clock_in);
  endtask
  task sample(input logic [23:0] c, input logic [31:0] a);
    @(posedge clock_in);
    cond_data_in <= c; alt_data_in <= a; data_valid_in <= 1;
    @(posedge clock_in);
    data_valid_in <= 0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    finish_test;
  end
  initial begin
    {data_valid_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 0;
    {cond_data_in, alt_data_in, wdata_in, awaddr_in, araddr_in, awprot_in, arprot_in} = 0;
    wstrb_in = 4'hF; n_errors = 0; num_checks = 0; sys_rst_in = 1;
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 0;
    rd(8'h0C); chk(d, 32'h7D00_8300, "range reset");
    wr(8'h08, 32'h0000_4000);
    wr(8'h10, 32'h0064_0001);
    wr(8'h14, 32'h0000_03E8);
    foreach (rows[i]) begin
      sample(rows[i].src, 32'h0000_0000);
      chk(process_data_out, {rows[i].meas, 14'h0000, 1'b0, rows[i].sw}, "pd word");
      chk(out_of_range_out, rows[i].oor, "oor");
      chk(switch_out, {1'b0, rows[i].sw}, "switch");
      chk(last_pd, {rows[i].meas, 14'h0000, 1'b0, rows[i].sw}, "pd pulse");
    end
    wr(8'h10, 32'h0064_0011);
    repeat (2) @(posedge clock_in);
    #1 chk(switch_out, 2'b01, "low active");
    wr(8'h00, 32'h0000_FE01);
    wr(8'h04, 32'h0000_0064);
    sample(24'h000000, 32'h0000_7D00);
    chk(process_data_out, 32'h0258_FE01, "alt offset");
    rd(8'h40); chk(d, 32'h0000_0000, "unmapped data");
    chk(r, 2'b10, "unmapped resp");
    wr(8'h18, 32'h0000_0005);
    wr(8'h20, 32'h0000_0009);
    rd(8'h1C); chk(d, 32'h0000_0258, "static teach");
    wr(8'h1C, 32'h0000_1234);
    rd(8'h1C); chk(d, 32'h0000_0258, "sp locked");
    wr(8'h18, 32'h0000_000D);
    wr(8'h20, 32'h0000_000A);
    sample(24'h000000, 32'h0000_FA00);
    sample(24'h000000, 32'h0001_F400);
    wr(8'h20, 32'h0000_000B);
    repeat (60) @(posedge clock_in);
    rd(8'h1C); chk(d, 32'h0000_0640, "dynamic mean");
    wr(8'h20, 32'h0000_000A);
    sample(24'h000000, 32'h0000_7D00);
    wr(8'h20, 32'h0000_000C);
    repeat (60) @(posedge clock_in);
    rd(8'h1C); chk(d, 32'h0000_0640, "cancel keep");
    rd(8'h20); chk(d[2:0], 3'h1, "teach idle");
    wr(8'h20, 32'h0000_000A);
    sample(24'h000000, 32'h0000_7D00);
    wr(8'h20, 32'h0000_000B);
    wr(8'h20, 32'h0000_000C);
    repeat (60) @(posedge clock_in);
    rd(8'h1C); chk(d, 32'h0000_0640, "cancel divide");
    wr(8'h10, 32'h0064_0003);
    wr(8'h14, 32'h07D0_03E8);
    sample(24'h000000, 32'h0001_5E00); chk(process_data_out, 32'h05DC_FE01, "window in");
    sample(24'h000000, 32'h0001_E780); chk(process_data_out, 32'h0802_FE03, "window hyst");
    sample(24'h000000, 32'h0002_0080); chk(process_data_out, 32'h0866_FE02, "window out");
    wr(8'h10, 32'h0000_0002);
    sample(24'h000000, 32'h0001_E780); chk(process_data_out, 32'h0802_FE03, "two on");
    sample(24'h000000, 32'h0001_5E00); chk(process_data_out, 32'h05DC_FE01, "two hold");
    sample(24'h000000, 32'h0000_C800); chk(process_data_out, 32'h0384_FE00, "two off");
    wr(8'h0C, 32'h0708_0000); chk(r, 2'b00, "write okay");
    sample(24'h000000, 32'h0001_E780); chk(process_data_out, 32'h7FF8_FE03, "range subst");
    chk(out_of_range_out, 1'b1, "range oor");
    wr(8'h44, 32'h0000_0000); chk(r, 2'b10, "write unmapped");
    @(posedge clock_in);
    sys_rst_in <= 1;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 0;
    @(posedge clock_in);
    #1 chk(process_data_out, 32'h0000_0000, "pd after reset");
    chk(out_of_range_out, 1'b0, "oor after reset");
    rd(8'h0C); chk(d, 32'h7D00_8300, "range after reset");
    finish_test;
  end
endmodule
